// ---- design/lai_timing.sv ----
// integration timing engine with axi4-lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "lai_params.svh"
module lai_timing import lai_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter front end
  output logic osc_tick,
  output logic integrating,
  output logic diode_sel2,
  output logic conv_done
);
  logic [7:0] cmd_r, ctl_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] div_r;
  logic half_r;
  logic [16:0] cnt_r;
  logic [15:0] timer_r;
  logic phase_r;
  logic ovf_r;
  logic wr_go, sync_pulse, ext_mode, full_rate, last_cyc, end_int;
  logic cmd_wr;
  logic [16:0] target;
  lai_diode_e dsel;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; unmapped writes are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= `LAI_CMD_RST;
      ctl_r <= `LAI_CTL_RST;
    end else if (wr_go && wstrb_r[0]) begin
      if (awaddr_r == `LAI_CMD_OFS) begin
        cmd_r <= wdata_r[7:0];
      end
      if (awaddr_r == `LAI_CTL_OFS) begin
        ctl_r <= wdata_r[7:0];
      end
    end
  end

  // writing one to the sync word is a strobe, nothing is stored
  assign sync_pulse = wr_go && wstrb_r[0] && (awaddr_r == `LAI_SYNC_OFS) && wdata_r[0];
  assign cmd_wr = wr_go && wstrb_r[0] && (awaddr_r == `LAI_CMD_OFS);

  assign ext_mode = cmd_r[`LAI_EXT_BIT];
  assign full_rate = ctl_r[3];
  assign dsel = lai_diode_e'(cmd_r[3:2]);

  // oscillator: divider shared by both timing modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 8'h00;
      half_r <= 1'b0;
    end else if (div_r == `LAI_OSC_DIV - 8'd1) begin
      div_r <= 8'h00;
      half_r <= ~half_r;
    end else begin
      div_r <= div_r + 8'd1;
    end
  end
  // half rate drops every other full-rate tick
  assign osc_tick = (div_r == `LAI_OSC_DIV - 8'd1) && (full_rate || half_r);

  always_comb begin
    case (cmd_r[1:0])
      2'h0: target = 17'h10000;
      2'h1: target = 17'h01000;
      2'h2: target = 17'h00100;
      default: target = 17'h00010;
    endcase
  end

  assign last_cyc = osc_tick && (cnt_r + 17'd1 == target);
  assign end_int = ext_mode ? (sync_pulse && integrating) : last_cyc;

  // in internal mode conversions run back to back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      integrating <= 1'b0;
    end else if (dsel == LAI_NOP) begin
      integrating <= 1'b0;
    end else if (cmd_wr) begin
      // new configuration restarts timing, so the next strobe only starts
      integrating <= 1'b0;
    end else if (ext_mode) begin
      if (sync_pulse) begin
        integrating <= 1'b1;
      end
    end else begin
      integrating <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 17'h00000;
    end else if (end_int || (ext_mode && sync_pulse) || !integrating) begin
      cnt_r <= 17'h00000;
    end else if (osc_tick) begin
      cnt_r <= {1'b0, cnt_r[15:0] + 16'd1}; // 16-bit wrap
    end
  end

  // set beats clear: a wrap on the ending edge still marks the reading bad
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_r <= 1'b0;
    end else if (ext_mode && integrating && osc_tick && (cnt_r == 17'h0FFFF)) begin
      ovf_r <= 1'b1; // host broke the spacing limit
    end else if (end_int || (ext_mode && sync_pulse) || !integrating) begin
      ovf_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_r <= 16'h0000;
    end else if (end_int && ext_mode) begin
      timer_r <= cnt_r[15:0];
    end
  end

  // diode alternation in difference sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 1'b0;
    end else if ((dsel != LAI_DIFF) || cmd_wr) begin
      phase_r <= 1'b0;
    end else if (end_int) begin
      phase_r <= ~phase_r;
    end
  end
  assign diode_sel2 = (dsel == LAI_D2) || (dsel == LAI_DIFF && phase_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_done <= 1'b0;
    end else begin
      conv_done <= end_int;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `LAI_CMD_OFS: s_axi_rdata <= {24'h000000, cmd_r};
        `LAI_CTL_OFS: s_axi_rdata <= {24'h000000, ctl_r};
        `LAI_TLO_OFS: s_axi_rdata <= {24'h000000, timer_r[7:0]};
        `LAI_THI_OFS: s_axi_rdata <= {24'h000000, timer_r[15:8]};
        `LAI_STAT_OFS: s_axi_rdata <= {29'h00000000, ovf_r, phase_r, integrating};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- design/lai_params.svh ----
// constants for the light converter integration timing block
// Function
// - resolution exponent from command bits 1:0
// - internal mode ends after 2^n oscillator cycles
// - command bit 5 selects external timing
// - oscillator half rate in ranges 0 and 1
// - each sync ends integration, starts next
// - difference mode alternates diode one, two
// - external mode counts cycles, 65,536 limit
// - oscillator identical in both timing modes
// - completed count readable as full scale; timer bytes latch the count in external mode only
// - width codes 00..11 give 65536..16 cycles
// - gain range from control bits 3:2
// - latch counter into timer bytes, low first
// - diode select routes one, two, sequence, none
`ifndef LAI_PARAMS_SVH
`define LAI_PARAMS_SVH
`define LAI_CMD_OFS 8'h00
`define LAI_CTL_OFS 8'h04
`define LAI_SYNC_OFS 8'h08
`define LAI_TLO_OFS 8'h18
`define LAI_THI_OFS 8'h1C
`define LAI_STAT_OFS 8'h20
`define LAI_CMD_RST 8'h00
`define LAI_CTL_RST 8'h00
`define LAI_EXT_BIT 5
`define LAI_OSC_DIV 8'd100
`endif

// ---- design/lai_pkg.sv ----
// types for the light converter integration timing block
package lai_pkg;
  typedef enum logic [1:0] {
    LAI_D1, LAI_D2, LAI_DIFF, LAI_NOP
  } lai_diode_e;
endpackage

// ---- test/lai_timing_assertions.sv ----
// concurrent checks on the integration timing block ports
`timescale 1ns/1ps
module lai_timing_assertions (
  // clock, reset and handshakes
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  // converter front end
  input wire logic osc_tick, conv_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  chk_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  chk_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
    else $error("read response not okay");
  chk_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("conversion done longer than one cycle");
  chk_tick_gap: assert property (osc_tick |=> !osc_tick [*8])
    else $error("oscillator ticks too close");
endmodule
bind lai_timing lai_timing_assertions chk (.*);

// ---- test/lai_host_model.sv ----
// axi4-lite host model issuing configuration and sync writes
`timescale 1ns/1ps
module lai_host_model (
  // answers from the block
  input wire logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // requests
  output logic [7:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // one write per sync strobe; callers space strobes well under the counter limit
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    @(posedge aclk);
    {aw_p, w_p} = 2'b11;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw_p || w_p);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- test/light_adc_integration_timing_bench.sv ----
// self-checking bench for the integration timing block
`timescale 1ns/1ps
module light_adc_integration_timing_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic osc_tick, integrating, diode_sel2, conv_done;
  int bad_count = 0, check_count = 0, cyc = 0, ticks = 0;
  lai_timing dut (.*);
  lai_host_model host (.*);
  always #5 aclk = ~aclk;
  // ceiling sized for about 88k cycles of tests
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ticks <= ticks + int'(osc_tick);
    if (cyc == 100000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic compare(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t %s: got %0h want %0h", $time, m, g, e);
    end
  endtask
  task automatic t_internal(input logic [31:0] ctl, input logic [1:0] w, input int e);
    int t0;
    host.wr(8'h04, ctl);
    host.wr(8'h00, {30'h0, w});
    do @(posedge aclk); while (conv_done !== 1'b1);
    t0 = cyc;
    do @(posedge aclk); while (conv_done !== 1'b1);
    compare(32'(cyc - t0), 32'(e), "period");
    $display("internal test done");
  endtask
  task automatic t_diff();
    host.wr(8'h00, 32'h0000_0028);
    for (int i = 0; i < 3; i++) begin
      host.wr(8'h08, 32'h0000_0001);
      compare({31'h0, diode_sel2}, 32'(i % 2), "diode");
      repeat (300) @(posedge aclk);
    end
    host.wr(8'h00, 32'h0000_0024);
    compare({31'h0, diode_sel2}, 32'h1, "diode two");
    host.wr(8'h00, 32'h0000_002C);
    host.wr(8'h08, 32'h0000_0001);
    compare({31'h0, integrating}, 32'h0, "no operation");
    $display("difference test done");
  endtask
  task automatic t_external();
    int t0;
    host.wr(8'h00, 32'h0000_0020);
    host.wr(8'h08, 32'h0000_0001);
    t0 = ticks;
    repeat (26000) @(posedge aclk);
    // keep the closing strobe clear of a tick so both counts agree
    do @(posedge aclk); while (osc_tick !== 1'b1);
    host.wr(8'h08, 32'h0000_0001);
    t0 = ticks - t0;
    compare({31'h0, integrating}, 32'h1, "integrating");
    host.rd(8'h20, rv);
    compare(rv, 32'h1, "status");
    host.rd(8'h18, rv);
    compare({24'h0, rv[7:0]}, {24'h0, 8'(t0)}, "timer low");
    host.rd(8'h1C, rv);
    compare({24'h0, rv[7:0]}, {24'h0, 8'(t0 >> 8)}, "timer high");
    host.rd(8'h08, rv);
    compare(rv, 32'h0, "sync reads zero");
    host.rd(8'h40, rv);
    compare(rv, 32'h0, "unmapped");
    $display("external test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_diff();
    t_internal(32'h0000_0008, 2'b11, 1600);
    t_internal(32'h0000_0000, 2'b11, 3200);
    t_internal(32'h0000_0008, 2'b10, 25600);
    t_external();
    complete_run();
  end
endmodule
